// [include/ioxp_pkg.sv]
// Constants, codes and state encodings shared by the sixteen-bit I/O expander.
`default_nettype none

package ioxp_pkg;

  // Fixed upper bits of the seven-bit slave address.
  localparam logic [3:0] ADDR_FIXED = 4'h4;

  // Register select codes carried in the low bits of the command byte.
  localparam logic [2:0] SEL_IN0 = 3'h0;
  localparam logic [2:0] SEL_IN1 = 3'h1;
  localparam logic [2:0] SEL_OUT0 = 3'h2;
  localparam logic [2:0] SEL_OUT1 = 3'h3;
  localparam logic [2:0] SEL_POL0 = 3'h4;
  localparam logic [2:0] SEL_POL1 = 3'h5;
  localparam logic [2:0] SEL_DIR0 = 3'h6;
  localparam logic [2:0] SEL_DIR1 = 3'h7;

  // Field positions inside the select code: bits 2..1 pick the kind, bit 0 the port.
  localparam int SEL_PORT_BIT = 0;
  localparam logic [1:0] KIND_IN = 2'h0;
  localparam logic [1:0] KIND_OUT = 2'h1;
  localparam logic [1:0] KIND_POL = 2'h2;
  localparam logic [1:0] KIND_DIR = 2'h3;

  // Power-up values of the registers; a direction bit of one means input.
  localparam logic [7:0] OUT_RESET = 8'hff;
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] IN_RESET = 8'h00;

  // Bit slot counter: slots 0..7 carry data, slot 8 is the acknowledge.
  localparam logic [3:0] SLOT_LAST_DATA = 4'h7;
  localparam logic [3:0] SLOT_ACK = 4'h8;
  localparam logic [3:0] SLOT_FIRST = 4'h0;

  // Serial protocol phases.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_CMD = 5'b00100,
    ST_WDATA = 5'b01000,
    ST_RDATA = 5'b10000
  } ioxp_state_t;

endpackage : ioxp_pkg

`default_nettype wire

// [design/ioxp_link.sv]
// Link-side bit sampler clocked by the serial clock line.
`timescale 1ns/1ns
`default_nettype none

module ioxp_link (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic sda_in,
  output logic bit_val,
  output logic bit_tgl
);

  // Each rising serial clock edge captures the data line and flips the toggle.
  // The captured bit then holds for a whole clock period, which is what lets the
  // core domain read it once it has seen the synchronised toggle change.
  // The clock stands still when the bus is idle, so reset acts without it.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      bit_val <= 1'b0;
      bit_tgl <= 1'b0;
    end else begin
      bit_val <= sda_in;
      bit_tgl <= ~bit_tgl;
    end
  end

  a_link_sample: assert property (@(posedge link_clk) disable iff (rst)
    ##1 (bit_val == $past(sda_in)) && (bit_tgl != $past(bit_tgl)))
    else $error("link sampler missed a serial clock edge");

endmodule : ioxp_link

`default_nettype wire

// [design/ioxp_core.sv]
// Sixteen-bit serial-bus I/O expander: protocol engine, registers, pins and alert.
`timescale 1ns/1ns
`default_nettype none

module ioxp_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic [7:0] port0_pin_in,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_pin_oe,
  output logic [7:0] port0_pullup_en,
  input wire logic [7:0] port1_pin_in,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe,
  output logic [7:0] port1_pullup_en,
  output logic alert_n_out,
  output logic alert_n_oe
);

  // Register file, one entry per port.
  logic [7:0] in_q [2];
  logic [7:0] out_q [2];
  logic [7:0] pol_q [2];
  logic [7:0] dir_q [2];
  logic [7:0] drv_q [2];

  // Pin and bus synchronisers; stage one is read only by stage two.
  logic [15:0] pins_s1_q;
  logic [15:0] pins_s2_q;
  logic [2:0] sel_s1_q;
  logic [2:0] sel_s2_q;
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;

  // Protocol state.
  ioxp_pkg::ioxp_state_t state_q;
  logic [3:0] slot_q;
  logic [6:0] shift_q;
  logic [2:0] ptr_q;
  logic [7:0] tx_q;
  logic ack_q;
  logic init_q;
  logic alert_q;

  logic link_bit;
  logic link_tgl;
  logic start_det, stop_det, scl_fall, bit_evt;
  logic [7:0] byte_in;
  logic byte_done, ack_done, addr_hit;
  logic wr_en, ld_en;
  logic [15:0] diff_bits;

  // Bit capture on the serial clock itself, crossed by toggle into this domain.
  ioxp_link i_ioxp_link (
    .link_clk(scl_clk),
    .rst(rst),
    .sda_in(sda_in),
    .bit_val(link_bit),
    .bit_tgl(link_tgl)
  );

  // Two-flop synchronisers for pins, strap pins, bus lines and the bit toggle.
  always_ff @(posedge core_clk) begin
    pins_s1_q <= {port1_pin_in, port0_pin_in};
    pins_s2_q <= pins_s1_q;
    sel_s1_q <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
    sel_s2_q <= sel_s1_q;
    scl_s1_q <= scl_in;
    scl_s2_q <= scl_s1_q;
    scl_s3_q <= scl_s2_q;
    sda_s1_q <= sda_in;
    sda_s2_q <= sda_s1_q;
    sda_s3_q <= sda_s2_q;
    tgl_s1_q <= link_tgl;
    tgl_s2_q <= tgl_s1_q;
    tgl_s3_q <= tgl_s2_q;
  end

  // Returns the byte the host sees for a select code; input bits pass through polarity.
  function automatic logic [7:0] reg_read(input logic [2:0] sel);
    logic [7:0] val;
    logic p;
    val = 8'h00;
    p = sel[ioxp_pkg::SEL_PORT_BIT];
    unique case (sel[2:1])
      ioxp_pkg::KIND_IN: val = (p ? pins_s2_q[15:8] : pins_s2_q[7:0]) ^ pol_q[p];
      ioxp_pkg::KIND_OUT: val = out_q[p];
      ioxp_pkg::KIND_POL: val = pol_q[p];
      ioxp_pkg::KIND_DIR: val = dir_q[p];
    endcase
    return val;
  endfunction : reg_read

  // Bus conditions: start and stop are data edges while the clock is high.
  // Our own data drive only changes after a clock fall, so it never fakes either.
  assign start_det = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  assign stop_det = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
  assign scl_fall = scl_s3_q && !scl_s2_q;
  assign bit_evt = (tgl_s2_q ^ tgl_s3_q) && (state_q != ioxp_pkg::ST_IDLE);
  assign byte_in = {shift_q, link_bit};
  assign byte_done = bit_evt && !start_det && !stop_det && (slot_q == ioxp_pkg::SLOT_LAST_DATA);
  assign ack_done = bit_evt && !start_det && !stop_det && (slot_q == ioxp_pkg::SLOT_ACK);
  assign addr_hit = (byte_in[7:1] == {ioxp_pkg::ADDR_FIXED, sel_s2_q});
  assign wr_en = byte_done && (state_q == ioxp_pkg::ST_WDATA);
  // A read byte is loaded after a read address match and after each master acknowledge.
  assign ld_en = (byte_done && (state_q == ioxp_pkg::ST_ADDR) && addr_hit && byte_in[0]) ||
                 (ack_done && (state_q == ioxp_pkg::ST_RDATA) && !ack_q && !link_bit);
  assign diff_bits = (pins_s2_q ^ {in_q[1], in_q[0]}) & {dir_q[1], dir_q[0]};

  // Protocol sequencer; a start always wins, then a stop, then the bit event.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ioxp_pkg::ST_IDLE;
      slot_q <= ioxp_pkg::SLOT_FIRST;
      shift_q <= 7'h00;
      ptr_q <= ioxp_pkg::SEL_IN0;
      ack_q <= 1'b0;
    end else if (start_det) begin
      state_q <= ioxp_pkg::ST_ADDR;
      slot_q <= ioxp_pkg::SLOT_FIRST;
      ack_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= ioxp_pkg::ST_IDLE;
      slot_q <= ioxp_pkg::SLOT_FIRST;
      ack_q <= 1'b0;
    end else if (ack_done) begin
      slot_q <= ioxp_pkg::SLOT_FIRST;
      ack_q <= 1'b0;
      // A master that does not acknowledge a read byte ends our part of the frame.
      if (state_q == ioxp_pkg::ST_RDATA && !ack_q && link_bit) begin
        state_q <= ioxp_pkg::ST_IDLE;
      end
    end else if (bit_evt) begin
      shift_q <= byte_in[6:0];
      slot_q <= slot_q + 4'h1;
      if (byte_done) begin
        unique case (state_q)
          ioxp_pkg::ST_ADDR: begin
            // A foreign address drops us to idle until the next start.
            ack_q <= addr_hit;
            if (!addr_hit) begin
              state_q <= ioxp_pkg::ST_IDLE;
            end else if (byte_in[0]) begin
              state_q <= ioxp_pkg::ST_RDATA;
            end else begin
              state_q <= ioxp_pkg::ST_CMD;
            end
          end
          ioxp_pkg::ST_CMD: begin
            ptr_q <= byte_in[2:0];
            ack_q <= 1'b1;
            state_q <= ioxp_pkg::ST_WDATA;
          end
          ioxp_pkg::ST_WDATA: begin
            ack_q <= 1'b1;
          end
          ioxp_pkg::ST_RDATA: begin
            ack_q <= 1'b0;
          end
          default: begin
            state_q <= ioxp_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Read data holds the same register for every byte until a new command arrives.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_q <= 8'h00;
    end else if (ld_en) begin
      tx_q <= reg_read(ptr_q);
    end
  end

  // Open-drain data line: ack and zero bits pull low, everything else releases.
  always_ff @(posedge core_clk) begin
    if (rst || start_det || stop_det || state_q == ioxp_pkg::ST_IDLE) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      if (slot_q == ioxp_pkg::SLOT_ACK) begin
        sda_oe <= ack_q;
      end else if (state_q == ioxp_pkg::ST_RDATA) begin
        sda_oe <= !tx_q[3'(ioxp_pkg::SLOT_LAST_DATA - slot_q)];
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end

  // Writable registers; the drive enables shadow the direction bits as flops.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        out_q[i] <= ioxp_pkg::OUT_RESET;
        pol_q[i] <= ioxp_pkg::POL_RESET;
        dir_q[i] <= ioxp_pkg::DIR_RESET;
        drv_q[i] <= ~ioxp_pkg::DIR_RESET;
      end
    end else if (wr_en) begin
      // Input kinds fall through with no effect.
      unique case (ptr_q[2:1])
        ioxp_pkg::KIND_IN: ;
        ioxp_pkg::KIND_OUT: out_q[ptr_q[0]] <= byte_in;
        ioxp_pkg::KIND_POL: pol_q[ptr_q[0]] <= byte_in;
        ioxp_pkg::KIND_DIR: begin
          dir_q[ptr_q[0]] <= byte_in;
          drv_q[ptr_q[0]] <= ~byte_in;
        end
      endcase
    end
  end

  // Input register: caught once after reset, then again on every host read of it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_q[0] <= ioxp_pkg::IN_RESET;
      in_q[1] <= ioxp_pkg::IN_RESET;
      init_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
      if (!init_q) begin
        in_q[0] <= pins_s2_q[7:0];
        in_q[1] <= pins_s2_q[15:8];
      end else if (ld_en && ptr_q[2:1] == ioxp_pkg::KIND_IN) begin
        if (ptr_q[0]) begin
          in_q[1] <= pins_s2_q[15:8];
        end else begin
          in_q[0] <= pins_s2_q[7:0];
        end
      end
    end
  end

  // Change alert, only for pins set as inputs; held off until the first capture.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= init_q && (|diff_bits);
    end
  end

  // Pin and alert drivers, all straight from flops.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alert_n_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      alert_n_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end
  assign alert_n_oe = alert_q;
  assign port0_pin_out = out_q[0];
  assign port1_pin_out = out_q[1];
  assign port0_pin_oe = drv_q[0];
  assign port1_pin_oe = drv_q[1];
  assign port0_pullup_en = dir_q[0];
  assign port1_pullup_en = dir_q[1];

  default clocking cb @(posedge core_clk); endclocking

  a_reset_defaults: assert property (rst |=> (port0_pin_oe == 8'h00) &&
    (port1_pin_oe == 8'h00) && (port0_pin_out == 8'hff) && (state_q == ioxp_pkg::ST_IDLE))
    else $error("reset left a pin driven or a register off default");

  a_dir_write: assert property (disable iff (rst)
    wr_en && ptr_q == ioxp_pkg::SEL_DIR0 |=> port0_pin_oe == ~$past(byte_in))
    else $error("direction write did not steer the drive enable");

  a_out_write: assert property (disable iff (rst)
    wr_en && ptr_q == ioxp_pkg::SEL_OUT1 |=> port1_pin_out == $past(byte_in))
    else $error("output write did not reach the pins");

  a_input_ignored: assert property (disable iff (rst)
    wr_en && ptr_q[2:1] == ioxp_pkg::KIND_IN |=>
    $stable(port0_pin_out) && $stable(port1_pin_out) && $stable(port0_pin_oe))
    else $error("write to an input register had an effect");

  a_polarity_read: assert property (disable iff (rst)
    ld_en && ptr_q == ioxp_pkg::SEL_IN1 |=> tx_q == ($past(pins_s2_q[15:8]) ^ pol_q[1]))
    else $error("input read ignored polarity inversion");

  a_dir_readback: assert property (disable iff (rst)
    ld_en && ptr_q == ioxp_pkg::SEL_DIR1 |=> tx_q == $past(dir_q[1]))
    else $error("direction register did not read back");

  a_alert_follows: assert property (disable iff (rst)
    init_q |=> alert_n_oe == (|$past(diff_bits)))
    else $error("alert does not follow the input mismatch");

  a_read_relatch: assert property (disable iff (rst)
    init_q && ld_en && ptr_q == ioxp_pkg::SEL_IN0 |=> in_q[0] == $past(pins_s2_q[7:0]))
    else $error("input read did not relatch the port");

  a_addr_ack: assert property (disable iff (rst)
    byte_done && state_q == ioxp_pkg::ST_ADDR && addr_hit && !start_det
    |=> ack_q ##[0:400] (scl_fall || start_det || stop_det))
    else $error("matching address not acknowledged");

  a_cmd_keeps: assert property (disable iff (rst)
    state_q != ioxp_pkg::ST_CMD |=> $stable(ptr_q))
    else $error("register pointer moved without a command byte");

  a_stop_idle: assert property (disable iff (rst)
    stop_det && !start_det |=> state_q == ioxp_pkg::ST_IDLE && !sda_oe)
    else $error("stop did not return the engine to idle");

endmodule : ioxp_core

`default_nettype wire

// [bench/ioxp_host_model.sv]
// Serial bus master model that drives the expander's clock and data lines.
`timescale 1ns/1ns
`default_nettype none

module ioxp_host_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // The clock stands high between frames; each phase lasts well over five core cycles.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    if (scl === 1'b0) begin
      #32 sda_low = 1'b0;
      #32 scl = 1'b1;
      #64;
    end
    sda_low = 1'b1;
    #64 scl = 1'b0;
  endtask : start

  // Data moves only deep in the low phase, so the core never sees a false start or stop.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #32 sda_low = ~b[i];
      #32 scl = 1'b1;
      #64 scl = 1'b0;
    end
    #32 sda_low = 1'b0;
    #32 scl = 1'b1;
    ack = ~sda;
    #64 scl = 1'b0;
  endtask : send_byte

  // Bits are taken at the rising clock; the final slot acknowledges only if more is wanted.
  task automatic recv_byte(input logic more, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #32 sda_low = 1'b0;
      #32 scl = 1'b1;
      b[i] = sda;
      #64 scl = 1'b0;
    end
    #32 sda_low = more;
    #32 scl = 1'b1;
    #64 scl = 1'b0;
  endtask : recv_byte

  // Stop: data rises while the clock is high, then the bus rests.
  task automatic stop();
    #32 sda_low = 1'b1;
    #32 scl = 1'b1;
    #64 sda_low = 1'b0;
    #64;
  endtask : stop
endmodule : ioxp_host_model

`default_nettype wire

// [bench/ioxp_core_tb.sv]
// Self-checking bench for the sixteen-bit serial-bus I/O expander.
`timescale 1ns/1ns
`default_nettype none

module ioxp_core_tb;
  logic core_clk, rst, scl, m_low, sda, sda_out, sda_oe, alert_n_out, alert_n_oe, alert_n;
  logic [2:0] strap;
  logic [7:0] ext0, ext_en, p0_lvl, p1_lvl, p0_out, p0_oe, p0_pu, p1_out, p1_oe, p1_pu;
  int errors, check_count;

  // Wired-and lines with pull-ups; undriven input pins rest at their pull-up level.
  assign sda = ~(m_low | (sda_oe & ~sda_out));
  assign alert_n = alert_n_oe ? alert_n_out : 1'b1;
  assign p0_lvl = (p0_oe & p0_out) | (~p0_oe & ext_en & ext0) | (~p0_oe & ~ext_en & p0_pu);
  assign p1_lvl = (p1_oe & p1_out) | (~p1_oe & p1_pu);

  // Core clock at 100 MHz.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ioxp_host_model i_ioxp_host_model (.scl(scl), .sda_low(m_low), .sda(sda));

  ioxp_core i_ioxp_core (
    .core_clk(core_clk), .rst(rst), .scl_clk(scl), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_bit0(strap[0]),
    .addr_select_bit1(strap[1]), .addr_select_bit2(strap[2]), .port0_pin_in(p0_lvl),
    .port0_pin_out(p0_out), .port0_pin_oe(p0_oe), .port0_pullup_en(p0_pu),
    .port1_pin_in(p1_lvl), .port1_pin_out(p1_out), .port1_pin_oe(p1_oe),
    .port1_pullup_en(p1_pu), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe)
  );

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // Address and command byte, leaving the bus open for data or a repeated start.
  task automatic set_ptr(input logic [2:0] cmd);
    logic a;
    i_ioxp_host_model.start();
    i_ioxp_host_model.send_byte({4'h4, strap, 1'b0}, a);
    check("address ack", 8'h01, {7'h0, a});
    i_ioxp_host_model.send_byte({5'h0, cmd}, a);
  endtask : set_ptr

  task automatic wr(input logic [2:0] cmd, input logic [7:0] d);
    logic a;
    set_ptr(cmd);
    i_ioxp_host_model.send_byte(d, a);
    i_ioxp_host_model.stop();
  endtask : wr

  // Read one byte from whatever register the pointer holds now.
  task automatic rd_now(output logic [7:0] d);
    logic a;
    i_ioxp_host_model.start();
    i_ioxp_host_model.send_byte({4'h4, strap, 1'b1}, a);
    i_ioxp_host_model.recv_byte(1'b0, d);
    i_ioxp_host_model.stop();
  endtask : rd_now

  task automatic rd(input logic [2:0] cmd, output logic [7:0] d);
    set_ptr(cmd);
    rd_now(d);
  endtask : rd

  // Bounded wait, since the alert passes a two-flop synchroniser first.
  task automatic wait_alert(input logic exp);
    int n;
    n = 0;
    while (alert_n !== exp && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    check("alert_n", {7'h0, exp}, {7'h0, alert_n});
  endtask : wait_alert

  task automatic do_reset();
    @(negedge core_clk);
    rst = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask : do_reset

  task automatic test_defaults();
    logic [7:0] d;
    check("p0 oe", 8'h00, p0_oe);
    check("p1 oe", 8'h00, p1_oe);
    check("p0 out", 8'hff, p0_out);
    check("p1 pull", 8'hff, p1_pu);
    wait_alert(1'b1);
    for (int c = 2; c < 8; c++) begin
      rd(c[2:0], d);
      check("reg", (c < 4 || c > 5) ? 8'hff : 8'h00, d);
    end
    rd(3'h1, d);
    check("in1", 8'hff, d);
    $display("test_defaults done");
  endtask : test_defaults

  task automatic test_address();
    logic a;
    for (int s = 0; s < 8; s++) begin
      @(negedge core_clk);
      strap = s[2:0];
      repeat (4) @(negedge core_clk);
      i_ioxp_host_model.start();
      i_ioxp_host_model.send_byte({4'h4, s[2:0] ^ 3'h1, 1'b0}, a);
      check("foreign ack", 8'h00, {7'h0, a});
      i_ioxp_host_model.stop();
      set_ptr(3'h2);
      i_ioxp_host_model.stop();
    end
    $display("test_address done");
  endtask : test_address

  task automatic test_outputs();
    logic [7:0] d;
    wr(3'h6, 8'h0f);
    wr(3'h2, 8'ha5);
    wr(3'h7, 8'h00);
    wr(3'h3, 8'h3c);
    repeat (3) @(negedge core_clk);
    check("p0 oe", 8'hf0, p0_oe);
    check("p0 out", 8'ha5, p0_out);
    check("p1 oe", 8'hff, p1_oe);
    check("p1 out", 8'h3c, p1_out);
    check("p0 pull", 8'h0f, p0_pu);
    rd(3'h6, d);
    check("dir0", 8'h0f, d);
    rd(3'h3, d);
    check("out1", 8'h3c, d);
    wait_alert(1'b1);
    $display("test_outputs done");
  endtask : test_outputs

  task automatic test_polarity();
    logic [7:0] d;
    @(negedge core_clk);
    ext0 = 8'h06;
    ext_en = 8'h0f;
    rd(3'h0, d);
    check("in0", 8'ha6, d);
    rd(3'h1, d);
    check("in1", 8'h3c, d);
    wr(3'h4, 8'hff);
    wr(3'h0, 8'h00);
    rd(3'h0, d);
    check("in0 inverted", 8'h59, d);
    rd(3'h4, d);
    check("pol0", 8'hff, d);
    wr(3'h4, 8'h00);
    // Port one is all outputs here, so its input bits follow the output register.
    wr(3'h5, 8'h0f);
    wr(3'h1, 8'h00);
    rd(3'h1, d);
    check("in1 inverted", 8'h33, d);
    check("p1 out kept", 8'h3c, p1_out);
    rd(3'h5, d);
    check("pol1", 8'h0f, d);
    wr(3'h5, 8'h00);
    $display("test_polarity done");
  endtask : test_polarity

  task automatic test_alert();
    logic [7:0] d;
    rd(3'h0, d);
    wait_alert(1'b1);
    @(negedge core_clk);
    ext0 = 8'h09;
    wait_alert(1'b0);
    check("alert drive", 8'h00, {7'h0, alert_n_out});
    @(negedge core_clk);
    ext0 = 8'h06;
    wait_alert(1'b1);
    @(negedge core_clk);
    ext0 = 8'h0b;
    wait_alert(1'b0);
    rd(3'h0, d);
    check("in0", 8'hab, d);
    wait_alert(1'b1);
    wr(3'h2, 8'h5a);
    repeat (10) @(negedge core_clk);
    check("alert idle", 8'h01, {7'h0, alert_n});
    $display("test_alert done");
  endtask : test_alert

  task automatic test_pointer();
    logic [7:0] d;
    set_ptr(3'h3);
    i_ioxp_host_model.stop();
    rd_now(d);
    check("kept out1", 8'h3c, d);
    i_ioxp_host_model.start();
    i_ioxp_host_model.send_byte({4'h4, strap, 1'b1}, d[0]);
    i_ioxp_host_model.recv_byte(1'b1, d);
    check("first byte", 8'h3c, d);
    i_ioxp_host_model.recv_byte(1'b0, d);
    check("second byte", 8'h3c, d);
    i_ioxp_host_model.stop();
    $display("test_pointer done");
  endtask : test_pointer

  // A reset in mid-frame must free the data line and bring back every default.
  task automatic test_reset_recovery();
    logic a;
    i_ioxp_host_model.start();
    i_ioxp_host_model.send_byte({4'h4, strap, 1'b0}, a);
    check("ack before reset", 8'h01, {7'h0, a});
    do_reset();
    check("sda after reset", 8'h01, {7'h0, sda});
    check("p1 oe after reset", 8'h00, p1_oe);
    test_defaults();
    $display("test_reset_recovery done");
  endtask : test_reset_recovery

  // A hung transfer cannot stall the run past this limit.
  initial begin
    #500000;
    errors++;
    $display("[FAIL] run time expected 0 seen 1");
    report_and_stop();
  end

  // Main sequence; the last reset lands in mid-transfer to prove the engine recovers.
  initial begin
    rst = 1'b1;
    strap = 3'h0;
    ext0 = 8'h00;
    ext_en = 8'h00;
    errors = 0;
    check_count = 0;
    do_reset();
    test_defaults();
    test_address();
    test_outputs();
    test_polarity();
    test_alert();
    test_pointer();
    test_reset_recovery();
    report_and_stop();
  end
endmodule : ioxp_core_tb

`default_nettype wire
